// ### rtl/icsr_regs.svh
// Register offsets, field positions, reset values and sizes of the interrupt control and status block.
// Operation
// - Each source has a sticky request flag; sources 4, 14 and 15 have none here.
// - Cleared enable bit blocks source requests.
// - Each source has eight-level priority field.
// - Sources map to bits in vector order.
// - CPU priority field bits 7:5; 111 masks.
// - High priority bit extends level; set masks.
// - High priority bit is read-only to software.
// - Software writes CPU priority field normally.
// - Nesting disabled makes priority field read-only.
// - Pending register latches vector and level.
// - Control one bit 15 disables nesting.
// - Overflow and catastrophic flags at bits 14-11.
// - Trap enables at bits 10, 9, 8.
// - Math error status bits 7, 6, 4.
// - Address, stack, oscillator traps bits 3-1.
// - Control two bit 15 selects alternate table.
// - Control two bit 14 shows masking instruction.
// - Bits 2:0 set external pin edge polarity.
// - Unimplemented bits ignore writes, read zero.
// - Request presented only above current CPU level.
// - Nesting disabled forces priority 111 on entry.
// - Priority zero source is fully disabled.
`ifndef ICSR_REGS_SVH
`define ICSR_REGS_SVH
`define ICSR_NSRC          16
`define ICSR_ADDR_W        4
`define ICSR_OFF_STATUS    4'h0
`define ICSR_OFF_CORE      4'h1
`define ICSR_OFF_CTL1      4'h2
`define ICSR_OFF_CTL2      4'h3
`define ICSR_OFF_FLAGS     4'h4
`define ICSR_OFF_ENABLES   4'h5
`define ICSR_OFF_PRIO0     4'h6
`define ICSR_OFF_PRIO1     4'h7
`define ICSR_OFF_PRIO2     4'h8
`define ICSR_OFF_PRIO3     4'h9
`define ICSR_OFF_PENDING   4'hA
`define ICSR_PRIO_LOW_LSB  5
`define ICSR_PRIO_HIGH_BIT 3
`define ICSR_NEST_OFF_BIT  15
`define ICSR_CTL1_MASK     16'hFFDE
`define ICSR_ALT_BIT       15
`define ICSR_MASKING_BIT   14
`define ICSR_CTL2_WMASK    16'h8007
`define ICSR_FLAGS_MASK    16'h3FEF
`define ICSR_PRIO_RESET    16'h0000
`define ICSR_VEC_BASE      7'h08
`endif

// ### rtl/icsr_pkg.sv
// Types shared by the interrupt control and status block.
package icsr_pkg;
   // Grant sequencer states, Gray coded along idle, offer, in service.
   typedef enum logic [1:0] {
      ICSR_IDLE = 2'b00,
      ICSR_OFFER = 2'b01,
      ICSR_INSVC = 2'b11
   } icsr_state_t;
   // Trap event strobes from the core.
   typedef struct packed {
      logic acc_a_ovf;
      logic acc_b_ovf;
      logic acc_a_cat;
      logic acc_b_cat;
      logic bad_shift;
      logic div_zero;
      logic address;
      logic stack;
      logic osc_fail;
   } icsr_trap_t;
   // Winner of arbitration.
   typedef struct packed {
      logic       valid;
      logic [3:0] src;
      logic [2:0] level;
   } icsr_win_t;
endpackage

// ### rtl/icsr_arbiter.sv
// Priority arbiter choosing the highest pending source above the CPU level.
`timescale 1ns/1ns
`include "icsr_regs.svh"
module icsr_arbiter (
   // Source state.
   input  wire logic [`ICSR_NSRC-1:0]   req,
   input  wire logic [`ICSR_NSRC*3-1:0] prio,
   // Current CPU level, four bits.
   input  wire logic [3:0]              cpu_level,
   // Winning request.
   output icsr_pkg::icsr_win_t          win
);
   // Scan from the top so the lowest index wins on a tie.
   always_comb
   begin
      win = '0;
      for (int i = `ICSR_NSRC - 1; i >= 0; i--)
      begin
         // Level zero never wins, and neither does a level at or below the CPU's.
         if (req[i] && (prio[i*3 +: 3] != 3'h0) && ({1'b0, prio[i*3 +: 3]} > cpu_level) &&
             (!win.valid || (prio[i*3 +: 3] >= win.level)))
         begin
            win.valid = 1'b1;
            win.src = 4'(i);
            win.level = prio[i*3 +: 3];
         end
      end
   end
endmodule

// ### rtl/icsr_top.sv
// Interrupt control and status registers with request arbitration.
`timescale 1ns/1ns
`include "icsr_regs.svh"
module icsr_top (
   // Clock and reset.
   input  wire logic                     CORE_CLK,
   input  wire logic                     SRST,
   // Register port.
   input  wire logic [`ICSR_ADDR_W-1:0]  ADDR,
   input  wire logic [15:0]              WDATA,
   input  wire logic                     WR,
   input  wire logic                     RD,
   output logic [15:0]                   RDATA,
   // Peripheral request strobes, bit 0 is the external pin zero source.
   input  wire logic [`ICSR_NSRC-1:0]    SRC_EVENT,
   // External pins 0 to 2.
   input  wire logic [2:0]               EXT_PIN,
   // Trap event strobes from the core.
   input  wire icsr_pkg::icsr_trap_t     TRAP_EVENT,
   // Core state: masking instruction running, trap entry and exit.
   input  wire logic                     MASKING_ACTIVE,
   input  wire logic                     TRAP_ENTER,
   input  wire logic                     TRAP_EXIT,
   // Processor handshake.
   output logic                          IRQ,
   output logic [6:0]                    IRQ_VECTOR,
   output logic                          ALT_TABLE,
   input  wire logic                     IRQ_ACK,
   input  wire logic                     HANDLER_RETURN,
   // Priority levels stacked by the core and restored on return, plus wake and trap enable outputs.
   input  wire logic [3:0]               RESTORE_LEVEL,
   output logic [3:0]                    CPU_LEVEL,
   output logic                          WAKE,
   output logic [3:0]                    TRAP_ENABLES
);
   // Register state.
   logic [2:0]             prio_low_ff;   // CPU priority low field.
   logic                   prio_high_ff;  // CPU priority high bit.
   logic [15:0]            ctl1_ff;       // Control one register.
   logic                   alt_ff;        // Alternate table select.
   logic [2:0]             edge_pol_ff;   // External pin polarities.
   logic [`ICSR_NSRC-1:0]  flags_ff;      // Request flags.
   logic [`ICSR_NSRC-1:0]  enables_ff;    // Request enables.
   logic [`ICSR_NSRC*3-1:0] prio_ff;      // Priority fields, three bits a source.
   logic [6:0]             pend_vec_ff;   // Latched pending vector.
   logic [3:0]             pend_lvl_ff;   // Latched pending level.
   logic [2:0]             pin_ff;        // Previous pin levels.
   logic [15:0]            rdata_ff;      // Read data register.
   icsr_pkg::icsr_state_t  state_ff;      // Grant sequencer.
   icsr_pkg::icsr_state_t  nxt_state;     // Next sequencer state.
   icsr_pkg::icsr_win_t    win;           // Arbiter result.
   logic [`ICSR_NSRC-1:0]  set_evt;       // Per source set events.
   logic [2:0]             pin_edge;      // Edge detected per pin.
   logic [15:0]            rd_mux;        // Read value before registering.
   logic [15:0]            ctl1_set;      // Hardware set bits of control one.
   logic [`ICSR_NSRC-1:0]  active;        // Flagged and enabled sources.
   logic                   nest_off;      // Nesting disabled.

   assign nest_off = ctl1_ff[`ICSR_NEST_OFF_BIT];
   assign CPU_LEVEL = {prio_high_ff, prio_low_ff};
   assign active = flags_ff & enables_ff;

   // Pin edges honour the chosen polarity: one means falling, zero rising.
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_pin
         assign pin_edge[g] = edge_pol_ff[g] ? (pin_ff[g] & ~EXT_PIN[g]) : (~pin_ff[g] & EXT_PIN[g]);
      end
   endgenerate

   // Pin zero feeds source zero along with its strobe; other pins have no flag bit here.
   // Strobes on unimplemented flag positions are dropped so those bits keep reading zero.
   assign set_evt = (SRC_EVENT | {{(`ICSR_NSRC-1){1'b0}}, pin_edge[0]}) & `ICSR_FLAGS_MASK;

   // Trap status bits in control one, set by the core's strobes.
   always_comb
   begin
      ctl1_set = 16'h0000;
      ctl1_set[14] = TRAP_EVENT.acc_a_ovf;
      ctl1_set[13] = TRAP_EVENT.acc_b_ovf;
      ctl1_set[12] = TRAP_EVENT.acc_a_cat;
      ctl1_set[11] = TRAP_EVENT.acc_b_cat;
      ctl1_set[7] = TRAP_EVENT.bad_shift;
      ctl1_set[6] = TRAP_EVENT.div_zero;
      ctl1_set[4] = TRAP_EVENT.bad_shift | TRAP_EVENT.div_zero;
      ctl1_set[3] = TRAP_EVENT.address;
      ctl1_set[2] = TRAP_EVENT.stack;
      ctl1_set[1] = TRAP_EVENT.osc_fail;
   end
   assign TRAP_ENABLES = {ctl1_ff[10], ctl1_ff[9], ctl1_ff[8], 1'b0};

   // Arbiter over all flagged and enabled sources.
   icsr_arbiter u_arb (
      .req       (active),
      .prio      (prio_ff),
      .cpu_level (CPU_LEVEL),
      .win       (win)
   );

   // Previous pin levels for edge detection. Sampled during reset as well, so a pin that idles
   // high does not look like a rising edge in the first cycle after reset.
   always_ff @(posedge CORE_CLK)
   begin
      pin_ff <= EXT_PIN;
   end

   // Request flags: a set in the same cycle as a software clear wins.
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         flags_ff <= '0;
      else if (WR && ADDR == `ICSR_OFF_FLAGS)
         flags_ff <= (WDATA & `ICSR_FLAGS_MASK) | set_evt;
      else
         flags_ff <= flags_ff | set_evt;
   end

   // Enables and priority fields, plain software storage.
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         enables_ff <= '0;
         prio_ff <= '0;
      end
      else if (WR)
      begin
         // Four priority registers, four sources of three bits each, bit 3 of each nibble unused.
         case (ADDR)
            `ICSR_OFF_ENABLES: enables_ff <= WDATA & `ICSR_FLAGS_MASK;
            `ICSR_OFF_PRIO0: prio_ff[11:0] <= {WDATA[14:12], WDATA[10:8], WDATA[6:4], WDATA[2:0]};
            `ICSR_OFF_PRIO1: prio_ff[23:12] <= {WDATA[14:12], WDATA[10:8], WDATA[6:4], WDATA[2:0]};
            `ICSR_OFF_PRIO2: prio_ff[35:24] <= {WDATA[14:12], WDATA[10:8], WDATA[6:4], WDATA[2:0]};
            `ICSR_OFF_PRIO3: prio_ff[47:36] <= {WDATA[14:12], WDATA[10:8], WDATA[6:4], WDATA[2:0]};
            default: ;
         endcase
      end
   end

   // Control one: trap flags set by hardware, otherwise software storage.
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         ctl1_ff <= 16'h0000;
      else if (WR && ADDR == `ICSR_OFF_CTL1)
         ctl1_ff <= (WDATA & `ICSR_CTL1_MASK) | ctl1_set;
      else
         ctl1_ff <= ctl1_ff | ctl1_set;
   end

   // Control two: table select and pin polarities.
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         alt_ff <= 1'b0;
         edge_pol_ff <= 3'h0;
      end
      else if (WR && ADDR == `ICSR_OFF_CTL2)
      begin
         alt_ff <= WDATA[`ICSR_ALT_BIT];
         edge_pol_ff <= WDATA[2:0];
      end
   end
   assign ALT_TABLE = alt_ff;

   // Grant sequencer: offer, wait for the core's acknowledge, then return to idle.
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         icsr_pkg::ICSR_IDLE:
            if (win.valid)
               nxt_state = icsr_pkg::ICSR_OFFER;
         icsr_pkg::ICSR_OFFER:
            if (IRQ_ACK)
               nxt_state = icsr_pkg::ICSR_IDLE;
            else if (!win.valid)
               nxt_state = icsr_pkg::ICSR_IDLE;
         default:
            nxt_state = icsr_pkg::ICSR_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         state_ff <= icsr_pkg::ICSR_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Pending register follows the current winner until the core takes it.
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         pend_vec_ff <= 7'h00;
         pend_lvl_ff <= 4'h0;
      end
      else if (win.valid && !IRQ_ACK)
      begin
         pend_vec_ff <= `ICSR_VEC_BASE + {3'h0, win.src};
         pend_lvl_ff <= {1'b0, win.level};
      end
   end
   assign IRQ = (state_ff == icsr_pkg::ICSR_OFFER) && win.valid && !prio_high_ff;
   assign IRQ_VECTOR = pend_vec_ff;

   // CPU priority low field: entry, return, and software writes.
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         prio_low_ff <= 3'h0;
      else if (IRQ && IRQ_ACK)
         prio_low_ff <= nest_off ? 3'h7 : pend_lvl_ff[2:0];
      else if (HANDLER_RETURN || TRAP_EXIT)
         prio_low_ff <= RESTORE_LEVEL[2:0];
      else if (WR && ADDR == `ICSR_OFF_STATUS && !nest_off)
         prio_low_ff <= WDATA[`ICSR_PRIO_LOW_LSB +: 3];
   end

   // High priority bit moves only with trap entry and return, never by software.
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         prio_high_ff <= 1'b0;
      else if (TRAP_ENTER)
         prio_high_ff <= 1'b1;
      else if (HANDLER_RETURN || TRAP_EXIT)
         prio_high_ff <= RESTORE_LEVEL[3];
   end

   // Wake on any flagged, enabled, non-zero priority source.
   always_comb
   begin
      WAKE = 1'b0;
      for (int i = 0; i < `ICSR_NSRC; i++)
         if (active[i] && prio_ff[i*3 +: 3] != 3'h0)
            WAKE = 1'b1;
   end

   // Read multiplexer; unmapped offsets read zero.
   always_comb
   begin
      rd_mux = 16'h0000;
      case (ADDR)
         `ICSR_OFF_STATUS: rd_mux[`ICSR_PRIO_LOW_LSB +: 3] = prio_low_ff;
         `ICSR_OFF_CORE: rd_mux[`ICSR_PRIO_HIGH_BIT] = prio_high_ff;
         `ICSR_OFF_CTL1: rd_mux = ctl1_ff;
         `ICSR_OFF_CTL2: rd_mux = {alt_ff, MASKING_ACTIVE, 11'h000, edge_pol_ff};
         `ICSR_OFF_FLAGS: rd_mux = flags_ff;
         `ICSR_OFF_ENABLES: rd_mux = enables_ff;
         `ICSR_OFF_PRIO0: rd_mux = {1'b0, prio_ff[11:9], 1'b0, prio_ff[8:6], 1'b0, prio_ff[5:3], 1'b0, prio_ff[2:0]};
         `ICSR_OFF_PRIO1: rd_mux = {1'b0, prio_ff[23:21], 1'b0, prio_ff[20:18], 1'b0, prio_ff[17:15], 1'b0, prio_ff[14:12]};
         `ICSR_OFF_PRIO2: rd_mux = {1'b0, prio_ff[35:33], 1'b0, prio_ff[32:30], 1'b0, prio_ff[29:27], 1'b0, prio_ff[26:24]};
         `ICSR_OFF_PRIO3: rd_mux = {1'b0, prio_ff[47:45], 1'b0, prio_ff[44:42], 1'b0, prio_ff[41:39], 1'b0, prio_ff[38:36]};
         `ICSR_OFF_PENDING: rd_mux = {4'h0, pend_lvl_ff, 1'b0, pend_vec_ff};
         default: rd_mux = 16'h0000;
      endcase
   end

   // Read data appear one cycle after the strobe and hold until the next read.
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
         rdata_ff <= 16'h0000;
      else if (RD)
         rdata_ff <= rd_mux;
   end
   assign RDATA = rdata_ff;
endmodule

// ### bench/icsr_core_model.sv
// Behavioural processor core that takes offers and returns from handlers.
`timescale 1ns/1ns
module icsr_core_model (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       srst,
   // Offer and level from the block, controls from the bench.
   input  wire logic       irq,
   input  wire logic [3:0] cpu_level,
   input  wire logic [2:0] ack_wait,
   input  wire logic       ret_go,
   // Answers to the block, and a busy flag for the bench.
   output logic            irq_ack,
   output logic            handler_return,
   output logic [3:0]      restore_level,
   output logic            busy
);
   logic [3:0] stack[$]; // Levels saved on entry, newest last.
   int         cnt;      // Cycles the present offer has waited.
   // One process, so an entry and a return never share a cycle.
   always @(posedge clk)
   begin
      irq_ack <= 1'b0;
      handler_return <= 1'b0;
      // Outside a handler return the model offers the running low field with the high bit clear,
      // which is what a trap return must restore, since trap entry leaves the low field alone.
      restore_level <= {1'b0, cpu_level[2:0]};
      if (srst)
      begin
         stack.delete();
         cnt = 0;
         restore_level <= 4'h0;
      end
      else if (irq && !irq_ack && cnt >= int'(ack_wait))
      begin
         irq_ack <= 1'b1;
         stack.push_back(cpu_level);
         cnt = 0;
      end
      else if (ret_go && !handler_return && stack.size() != 0)
      begin
         handler_return <= 1'b1;
         restore_level <= stack.pop_back();
      end
      else
         cnt = irq ? cnt + 1 : 0;
      busy <= (stack.size() != 0);
   end
endmodule

// ### bench/icsr_props.sv
// Port assertions for the interrupt control and status block.
`timescale 1ns/1ns
`include "icsr_regs.svh"
module icsr_props (
   // Clock, reset and register writes.
   input wire logic                    CORE_CLK,
   input wire logic                    SRST,
   input wire logic [`ICSR_ADDR_W-1:0] ADDR,
   input wire logic [15:0]             WDATA,
   input wire logic                    WR,
   // Core handshake and levels.
   input wire logic                    TRAP_ENTER,
   input wire logic                    TRAP_EXIT,
   input wire logic                    IRQ,
   input wire logic [6:0]              IRQ_VECTOR,
   input wire logic                    ALT_TABLE,
   input wire logic                    IRQ_ACK,
   input wire logic                    HANDLER_RETURN,
   input wire logic [3:0]              RESTORE_LEVEL,
   input wire logic [3:0]              CPU_LEVEL
);
   logic nst_ff; // Mirror of the nesting disable bit.
   logic calm;   // No trap or return moves the level this cycle.
   assign calm = !TRAP_ENTER && !TRAP_EXIT && !HANDLER_RETURN;
   // The mirror follows software writes of control one.
   always_ff @(posedge CORE_CLK)
      if (SRST)
         nst_ff <= 1'b0;
      else if (WR && ADDR == `ICSR_OFF_CTL1)
         nst_ff <= WDATA[15];
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SRST);
   irq_masked_a: assert property ((CPU_LEVEL[3] || CPU_LEVEL[2:0] == 3'h7) |-> !IRQ)
      else $error("Offer at masking level.");
   vector_range_a: assert property (IRQ |-> IRQ_VECTOR inside {[7'h08:7'h17]})
      else $error("Vector out of range.");
   level_rise_a: assert property ((IRQ && IRQ_ACK && calm && !WR && !nst_ff) |=> CPU_LEVEL > $past(CPU_LEVEL))
      else $error("Entry did not raise level.");
   nest_entry_a: assert property ((IRQ && IRQ_ACK && calm && !WR && nst_ff) |=> CPU_LEVEL == 4'h7)
      else $error("Entry did not force 7.");
   level_write_a: assert property ((WR && ADDR == `ICSR_OFF_STATUS && !nst_ff && calm && !IRQ_ACK)
      |=> CPU_LEVEL[2:0] == $past(WDATA[7:5])) else $error("Level write lost.");
   level_locked_a: assert property ((WR && ADDR == `ICSR_OFF_STATUS && nst_ff && calm && !IRQ_ACK)
      |=> $stable(CPU_LEVEL)) else $error("Locked level changed.");
   high_bit_ro_a: assert property ((WR && ADDR == `ICSR_OFF_CORE && calm) |=> $stable(CPU_LEVEL[3]))
      else $error("High bit written.");
   trap_entry_a: assert property ((TRAP_ENTER && !TRAP_EXIT && !HANDLER_RETURN) |=> CPU_LEVEL[3])
      else $error("Trap entry missed.");
   return_level_a: assert property ((HANDLER_RETURN && !TRAP_ENTER && !TRAP_EXIT && !WR && !IRQ_ACK)
      |=> CPU_LEVEL == $past(RESTORE_LEVEL)) else $error("Return level wrong.");
   alt_table_a: assert property ((WR && ADDR == `ICSR_OFF_CTL2) |=> ALT_TABLE == $past(WDATA[15]))
      else $error("Table select wrong.");
endmodule
bind icsr_top icsr_props u_props (.CORE_CLK, .SRST, .ADDR, .WDATA, .WR, .TRAP_ENTER, .TRAP_EXIT, .IRQ,
   .IRQ_VECTOR, .ALT_TABLE, .IRQ_ACK, .HANDLER_RETURN, .RESTORE_LEVEL, .CPU_LEVEL);

// ### bench/icsr_top_tb_top.sv
// Self-checking bench for the interrupt control and status block.
`timescale 1ns/1ns
`include "icsr_regs.svh"
module icsr_top_tb_top;
   logic                    clk, srst, wr_en, rd_en, masking, irq, irq_ack, hret, busy, wake;
   logic                    trap_enter, trap_exit, ret_go;
   logic [`ICSR_ADDR_W-1:0] addr;
   logic [15:0]             wdata, rdata, src, en, fl, w;
   logic [6:0]              vec;
   logic [3:0]              restore, cpu_level, trap_en;
   logic [2:0]              pin, ack_wait;
   icsr_pkg::icsr_trap_t    trap;
   int                      n_fail, comparisons, lv, nst, ma, b, k, wk, pr[16];
   int                      tpos[9] = '{14, 13, 12, 11, 7, 6, 3, 2, 1}; // Status bit of each trap strobe.
   icsr_top DUT (.CORE_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata),
      .SRC_EVENT(src), .EXT_PIN(pin), .TRAP_EVENT(trap), .MASKING_ACTIVE(masking), .TRAP_ENTER(trap_enter),
      .TRAP_EXIT(trap_exit), .IRQ(irq), .IRQ_VECTOR(vec), .ALT_TABLE(), .IRQ_ACK(irq_ack), .HANDLER_RETURN(hret),
      .RESTORE_LEVEL(restore), .CPU_LEVEL(cpu_level), .WAKE(wake), .TRAP_ENABLES(trap_en));
   icsr_core_model u_core (.clk(clk), .srst(srst), .irq(irq), .cpu_level(cpu_level), .ack_wait(ack_wait),
      .ret_go(ret_go), .irq_ack(irq_ack), .handler_return(hret), .restore_level(restore), .busy(busy));
   // Clock and watchdog; the tests need well under two thousand cycles.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      end_sim();
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Strobes last one cycle; controls, source events and trap events share it.
   task automatic strobe(input logic [2:0] s, input logic [15:0] v, input logic [8:0] t);
      @(posedge clk);
      {trap_enter, trap_exit, ret_go, src, trap} <= {s, v, t};
      @(posedge clk);
      {trap_enter, trap_exit, ret_go, src, trap} <= '0;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      {addr, wdata, wr_en} <= {a, d, 1'b1};
      @(posedge clk);
      wr_en <= 1'b0;
      @(negedge clk);
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      {addr, rd_en} <= {a, 1'b1};
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      {srst, wr_en, rd_en, masking, trap_enter, trap_exit, ret_go, addr, wdata, src, pin, trap, ack_wait} = '0;
      srst = 1'b1;
      void'($urandom(32'hE5DC8385));
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 16; a++)
         reg_rd(4'(a), 16'h0000);
      reg_wr(`ICSR_OFF_CORE, 16'hFFFF);
      reg_rd(`ICSR_OFF_CORE, 16'h0000);
      strobe(3'h4, 16'h0000, 9'h000);
      reg_rd(`ICSR_OFF_CORE, 16'h0008);
      strobe(3'h2, 16'h0000, 9'h000);
      reg_rd(`ICSR_OFF_CORE, 16'h0000);
      w = 16'($urandom) & 16'h7FFF;
      reg_wr(`ICSR_OFF_CTL1, w);
      chk(16'(trap_en), {12'h000, w[10:8], 1'b0});
      reg_rd(`ICSR_OFF_CTL1, w & `ICSR_CTL1_MASK);
      for (int i = 0; i < 9; i++)
      begin
         reg_wr(`ICSR_OFF_CTL1, 16'h0000);
         strobe(3'h0, 16'h0000, 9'h100 >> i);
         w = (16'h0001 << tpos[i]) | ((i == 4 || i == 5) ? 16'h0010 : 16'h0000);
         reg_rd(`ICSR_OFF_CTL1, w);
      end
      // Wrong edge first, then the selected edge, for each polarity.
      for (int p = 0; p < 2; p++)
      begin
         reg_wr(`ICSR_OFF_CTL2, 16'(p));
         @(posedge clk);
         pin <= 3'(p) ^ 3'h1;
         reg_wr(`ICSR_OFF_FLAGS, 16'h0000);
         @(posedge clk);
         pin <= 3'(p) | 3'h6;
         reg_rd(`ICSR_OFF_FLAGS, 16'h0000);
         @(posedge clk);
         pin <= 3'(p) ^ 3'h1;
         reg_rd(`ICSR_OFF_FLAGS, 16'h0001);
      end
      // Strobes on every position: unimplemented flags must stay clear.
      strobe(3'h0, 16'hFFFF, 9'h000);
      reg_rd(`ICSR_OFF_FLAGS, `ICSR_FLAGS_MASK);
      // A set strobe in the cycle of a software clear must win.
      fork
         reg_wr(`ICSR_OFF_FLAGS, 16'h0000);
         strobe(3'h0, 16'h0002, 9'h000);
      join
      reg_rd(`ICSR_OFF_FLAGS, 16'h0002);
      reg_wr(`ICSR_OFF_FLAGS, 16'h0000);
      repeat (30)
      begin
         ma = $urandom_range(0, 1);
         nst = $urandom_range(0, 1);
         lv = $urandom_range(0, 6);
         @(posedge clk);
         {masking, ack_wait} <= {ma[0], 3'($urandom_range(0, 3))};
         reg_wr(`ICSR_OFF_CTL1, 16'h0000);
         reg_wr(`ICSR_OFF_STATUS, 16'(lv << 5));
         reg_wr(`ICSR_OFF_CTL1, 16'(nst << 15));
         w = 16'($urandom_range(0, 7) << 5);
         reg_wr(`ICSR_OFF_STATUS, w);
         lv = nst ? lv : int'(w[7:5]);
         chk(16'(cpu_level), 16'(lv));
         w = 16'($urandom) & 16'hFFFE;
         reg_wr(`ICSR_OFF_CTL2, w);
         reg_rd(`ICSR_OFF_CTL2, (w & `ICSR_CTL2_WMASK) | 16'(ma << 14));
         for (int q = 0; q < 4; q++)
         begin
            w = 16'($urandom) & 16'h7777;
            reg_wr(`ICSR_OFF_PRIO0 + 4'(q), w);
            for (int j = 0; j < 4; j++)
               pr[4 * q + j] = int'(w[4 * j +: 3]);
         end
         en = 16'($urandom) & `ICSR_FLAGS_MASK;
         fl = 16'($urandom) & `ICSR_FLAGS_MASK;
         reg_wr(`ICSR_OFF_ENABLES, en);
         b = -1;
         wk = 0;
         for (int s = 0; s < 16; s++)
         begin
            if (fl[s] && en[s] && pr[s] > lv && (b < 0 || pr[s] > pr[b]))
               b = s;
            if (fl[s] && en[s] && pr[s] != 0)
               wk = 1;
         end
         strobe(3'h0, fl, 9'h000);
         for (k = 0; k < 6 && irq !== 1'b1; k++)
            @(negedge clk);
         chk(16'(irq), 16'(b >= 0));
         if (b >= 0)
         begin
            chk(16'(vec), 16'(8 + b));
            for (k = 0; k < 8 && irq_ack !== 1'b1; k++)
               @(negedge clk);
            @(negedge clk);
            chk(16'(cpu_level), nst ? 16'h0007 : 16'(pr[b]));
            reg_rd(`ICSR_OFF_PENDING, 16'((pr[b] << 8) | (8 + b)));
         end
         chk(16'(wake), 16'(wk));
         reg_rd(`ICSR_OFF_FLAGS, fl);
         reg_wr(`ICSR_OFF_ENABLES, 16'h0000);
         reg_wr(`ICSR_OFF_FLAGS, 16'h0000);
         for (k = 0; k < 4 && busy; k++)
         begin
            strobe(3'h1, 16'h0000, 9'h000);
            repeat (2) @(negedge clk);
         end
         chk(16'(cpu_level), 16'(lv));
      end
      end_sim();
   end
endmodule
